// ===== rtl/codec_i2c_regs.svh
// Constants for the codec two-wire register access port
`ifndef CODEC_I2C_REGS_SVH
`define CODEC_I2C_REGS_SVH

// Seven-bit slave address the port answers to
`define CODEC_SLAVE_ADDR 7'h20
// Highest implemented register index; above it is reserved
`define CODEC_LAST_REG 8'h1C
// Number of implemented registers (0x00 through 0x1C)
`define CODEC_REG_COUNT 29
// Pointer value taken when a read starts without a preset pointer
`define CODEC_PTR_RESET 8'h00
// Reset value of every stored register
`define CODEC_REG_RESET 8'h00
// Value read back from a reserved register index
`define CODEC_RESERVED_READ 8'h00
// Bit counter value of the last bit of a byte
`define CODEC_LAST_BIT 3'h7
// Level of an idle bus line
`define CODEC_BUS_IDLE 1'b1
// Read/write bit value that selects a read
`define CODEC_RW_READ 1'b1

`endif

// ===== rtl/codec_i2c_pkg.sv
// Types shared by the codec two-wire register access port
package codec_i2c_pkg;

  // Protocol states of the serial slave
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_MACK,
    ST_WAIT
  } link_state_type;

endpackage

// ===== rtl/pin_sync.sv
// Three-stage pin synchroniser with agreement filter for the bus lines
`timescale 1ns/10ps
`include "codec_i2c_regs.svh"

module pin_sync (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [1:0] pin_raw,
  output logic [1:0] pin_filt
);

  logic [1:0] ff1_q;
  logic [1:0] ff2_q;
  logic [1:0] ff3_q;
  logic [1:0] filt_q;
  logic [1:0] filt_d;

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_bit
      // A new level is taken only once stages two and three agree
      always_comb begin
        filt_d[i] = (ff2_q[i] == ff3_q[i]) ? ff2_q[i] : filt_q[i];
      end

      // Lines reset to the idle-high level so no false edge is seen at release
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          ff1_q[i] <= `CODEC_BUS_IDLE;
          ff2_q[i] <= `CODEC_BUS_IDLE;
          ff3_q[i] <= `CODEC_BUS_IDLE;
          filt_q[i] <= `CODEC_BUS_IDLE;
        end else begin
          ff1_q[i] <= pin_raw[i];
          ff2_q[i] <= ff1_q[i];
          ff3_q[i] <= ff2_q[i];
          filt_q[i] <= filt_d[i];
        end
      end
    end
  endgenerate

  assign pin_filt = filt_q;

endmodule

// ===== rtl/codec_i2c_register_access.sv
// Two-wire serial slave giving a bus master access to the codec control registers
`timescale 1ns/10ps
`include "codec_i2c_regs.svh"

// Summary of operation
// (RQ1) Master never writes register indexes above 0x1C; those are reserved.
// (RQ2) Own address with read bit set is acknowledged low through the 9th pulse.
// (RQ3) A START then read address resets the pointer to 0x00.
// (RQ4) Read data bits are driven after the falling edge, stable by the rising edge.
// (RQ5) Pointer advances by one after every byte transmitted in a read.
// (RQ6) A STOP at any byte boundary ends a read cleanly.
// (RQ7) A new read after STOP without a pointer write starts at register 0x00.
// (RQ8) Write address, index, repeated START, read address returns the indexed register.
// (RQ9) Master acknowledges each read byte except the last, then not-acknowledge and STOP.
// (RQ10) Fixed slave address 0x20 in upper seven bits; low bit one means read.
// (RQ11) In write mode each received byte is acknowledged low through the 9th pulse.
// (RQ12) First write byte loads pointer; later bytes store at pointer, then pointer increments.
// (RQ13) On master not-acknowledge the data line is released until START or STOP.
module codec_i2c_register_access
  import codec_i2c_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic wr_strobe,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic busy
);

  logic [1:0] line_filt;
  logic scl_f;
  logic sda_f;
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  link_state_type state_q;
  link_state_type state_d;
  logic [7:0] rx_q;
  logic [7:0] rx_d;
  logic [7:0] tx_q;
  logic [7:0] tx_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic byte_done_q;
  logic byte_done_d;
  logic read_q;
  logic read_d;
  logic ack_ok_q;
  logic ack_ok_d;
  logic [7:0] ptr_q;
  logic [7:0] ptr_d;
  logic ptr_set_q;
  logic ptr_set_d;
  logic oe_n_q;
  logic oe_n_d;
  logic wr_strobe_q;
  logic wr_strobe_d;
  logic [7:0] wr_addr_q;
  logic [7:0] wr_addr_d;
  logic [7:0] wr_data_q;
  logic [7:0] wr_data_d;
  logic busy_q;
  logic busy_d;
  logic mem_we;
  logic [7:0] rd_byte;

  logic [7:0] regs_q [`CODEC_REG_COUNT];

  // Both bus lines come from another domain and are filtered before use
  pin_sync u_pin_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_raw({scl_in, sda_in}),
    .pin_filt(line_filt)
  );

  assign scl_f = line_filt[1];
  assign sda_f = line_filt[0];

  // Edge and condition detection on the filtered lines
  assign scl_rise = scl_f & ~scl_prev_q;
  assign scl_fall = ~scl_f & scl_prev_q;
  assign start_det = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
  assign stop_det = scl_f & scl_prev_q & ~sda_prev_q & sda_f;

  // Reserved indexes read as a fixed value instead of indexing past the array
  always_comb begin
    if (ptr_q <= `CODEC_LAST_REG) begin
      rd_byte = regs_q[ptr_q[4:0]];
    end else begin
      rd_byte = `CODEC_RESERVED_READ;
    end
  end

  // Next values of the protocol engine
  always_comb begin
    state_d = state_q;
    rx_d = rx_q;
    tx_d = tx_q;
    cnt_d = cnt_q;
    byte_done_d = byte_done_q;
    read_d = read_q;
    ack_ok_d = ack_ok_q;
    ptr_d = ptr_q;
    ptr_set_d = ptr_set_q;
    oe_n_d = oe_n_q;
    wr_strobe_d = 1'b0;
    wr_addr_d = wr_addr_q;
    wr_data_d = wr_data_q;
    mem_we = 1'b0;
    case (state_q)
      ST_IDLE, ST_WAIT: begin
        oe_n_d = 1'b1;
      end
      ST_ADDR, ST_PTR, ST_WDATA: begin
        // Bits are sampled on the rising edge while the master holds them
        if (scl_rise) begin
          rx_d = {rx_q[6:0], sda_f};
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == `CODEC_LAST_BIT) begin
            byte_done_d = 1'b1;
          end
        end
        // Byte handling waits for the falling edge so the ack lands in the 9th pulse
        if (scl_fall && byte_done_q) begin
          byte_done_d = 1'b0;
          cnt_d = 3'h0;
          if (state_q == ST_ADDR) begin
            if (rx_q[7:1] == `CODEC_SLAVE_ADDR) begin // see (RQ10)
              oe_n_d = 1'b0; // see (RQ2)
              state_d = ST_ADDR_ACK;
              read_d = (rx_q[0] == `CODEC_RW_READ);
              if (rx_q[0] == `CODEC_RW_READ) begin
                if (!ptr_set_q) begin
                  ptr_d = `CODEC_PTR_RESET; // see (RQ3) (RQ7)
                end
                ptr_set_d = 1'b0; // see (RQ8)
              end
            end else begin
              state_d = ST_WAIT;
            end
          end else if (state_q == ST_PTR) begin
            ptr_d = rx_q; // see (RQ12)
            ptr_set_d = 1'b1; // see (RQ8)
            oe_n_d = 1'b0; // see (RQ11)
            state_d = ST_PTR_ACK;
          end else begin
            // Reserved indexes are acknowledged but not stored
            if (ptr_q <= `CODEC_LAST_REG) begin // see (RQ1)
              mem_we = 1'b1;
              wr_strobe_d = 1'b1;
              wr_addr_d = ptr_q;
              wr_data_d = rx_q;
            end
            ptr_d = ptr_q + 8'h01; // see (RQ12)
            oe_n_d = 1'b0; // see (RQ11)
            state_d = ST_WDATA_ACK;
          end
        end
      end
      ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK: begin
        // Ack is held low until the 9th pulse falls
        if (scl_fall) begin
          if (state_q == ST_ADDR_ACK && read_q) begin
            tx_d = rd_byte; // see (RQ8)
            oe_n_d = rd_byte[7]; // see (RQ4)
            state_d = ST_RDATA;
          end else begin
            oe_n_d = 1'b1;
            state_d = (state_q == ST_ADDR_ACK) ? ST_PTR : ST_WDATA;
          end
        end
      end
      ST_RDATA: begin
        // Next bit is placed right after the falling edge, well before the rise
        if (scl_fall) begin
          if (cnt_q == `CODEC_LAST_BIT) begin
            cnt_d = 3'h0;
            oe_n_d = 1'b1;
            ptr_d = ptr_q + 8'h01; // see (RQ5)
            ack_ok_d = 1'b0;
            state_d = ST_MACK;
          end else begin
            cnt_d = cnt_q + 3'h1;
            tx_d = {tx_q[6:0], 1'b0};
            oe_n_d = tx_q[6]; // see (RQ4)
          end
        end
      end
      ST_MACK: begin
        if (scl_rise) begin
          ack_ok_d = ~sda_f; // see (RQ9)
        end
        if (scl_fall) begin
          if (ack_ok_q) begin
            tx_d = rd_byte;
            oe_n_d = rd_byte[7];
            state_d = ST_RDATA;
          end else begin
            oe_n_d = 1'b1; // see (RQ13)
            state_d = ST_WAIT;
          end
        end
      end
      default: begin
        oe_n_d = 1'b1;
        state_d = ST_IDLE;
      end
    endcase
    // Bus conditions override every state; STOP wins if both were seen
    if (stop_det) begin
      state_d = ST_IDLE; // see (RQ6)
      oe_n_d = 1'b1;
      ptr_set_d = 1'b0; // see (RQ7)
      byte_done_d = 1'b0;
      cnt_d = 3'h0;
    end else if (start_det) begin
      state_d = ST_ADDR;
      oe_n_d = 1'b1;
      byte_done_d = 1'b0;
      cnt_d = 3'h0;
    end
    busy_d = (state_d != ST_IDLE);
  end

  // Protocol engine registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      scl_prev_q <= `CODEC_BUS_IDLE;
      sda_prev_q <= `CODEC_BUS_IDLE;
      state_q <= ST_IDLE;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      cnt_q <= 3'h0;
      byte_done_q <= 1'b0;
      read_q <= 1'b0;
      ack_ok_q <= 1'b0;
      ptr_q <= `CODEC_PTR_RESET;
      ptr_set_q <= 1'b0;
      oe_n_q <= 1'b1;
      wr_strobe_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
      busy_q <= 1'b0;
    end else begin
      scl_prev_q <= scl_f;
      sda_prev_q <= sda_f;
      state_q <= state_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      cnt_q <= cnt_d;
      byte_done_q <= byte_done_d;
      read_q <= read_d;
      ack_ok_q <= ack_ok_d;
      ptr_q <= ptr_d;
      ptr_set_q <= ptr_set_d;
      oe_n_q <= oe_n_d;
      wr_strobe_q <= wr_strobe_d;
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
      busy_q <= busy_d;
    end
  end

  // Register storage; only the implemented range exists
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int k = 0; k < `CODEC_REG_COUNT; k++) begin
        regs_q[k] <= `CODEC_REG_RESET;
      end
    end else if (mem_we) begin
      regs_q[ptr_q[4:0]] <= rx_q; // see (RQ12)
    end
  end

  // Open drain: the line is only ever pulled low, never driven high
  assign sda_out = 1'b0;
  assign sda_oe_n = oe_n_q;
  assign wr_strobe = wr_strobe_q;
  assign wr_addr = wr_addr_q;
  assign wr_data = wr_data_q;
  assign busy = busy_q;

endmodule

// ===== dv/codec_i2c_register_access_properties.sv
// Port-level assertions for the codec two-wire register access port
`timescale 1ns/10ps

module codec_i2c_register_access_properties (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic wr_strobe,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic busy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // A store is a single-cycle pulse
  sequence s_store;
    wr_strobe ##1 !wr_strobe;
  endsequence

  a_store_pulse: assert property (wr_strobe |-> s_store)
    else $error("store strobe longer than one cycle");
  a_store_acked: assert property (wr_strobe |-> ##[0:1] !sda_oe_n)
    else $error("stored byte not acknowledged");
  a_store_range: assert property (wr_strobe |-> wr_addr <= 8'h1C)
    else $error("store to reserved index");
  a_store_hold: assert property (!wr_strobe |-> $stable(wr_addr) && $stable(wr_data))
    else $error("store outputs moved without strobe");
  a_pull_after_fall: assert property ($fell(sda_oe_n) |-> !scl_in)
    else $error("data line pulled while clock high");
  a_drive_zero: assert property (sda_out == 1'b0)
    else $error("open drain value not low");
  a_idle_released: assert property (!busy |-> sda_oe_n)
    else $error("data line held while idle");
  a_store_busy: assert property (wr_strobe |-> busy)
    else $error("store outside a frame");
  // Pin conditions reach the engine through the filter, a handful of cycles late
  a_start_busy: assert property ($fell(sda_in) && scl_in |-> ##[1:8] busy)
    else $error("start condition not followed by busy");
  a_stop_idle: assert property ($rose(sda_in) && scl_in |-> ##[1:8] !busy)
    else $error("stop condition not followed by idle");
  // Reset must quiet the outputs regardless of the default disable
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> sda_oe_n && !busy && !wr_strobe)
    else $error("outputs active after reset");
endmodule

bind codec_i2c_register_access codec_i2c_register_access_properties chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data), .busy(busy)
);

// ===== dv/i2c_master_model.sv
// Behavioural two-wire bus master driving the clock and its share of the data wire
`timescale 1ns/10ps

module i2c_master_model (
  output logic scl,
  output logic sda_m,
  input wire logic sda
);
  // Clock stands high between frames; phases of 40 ns
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  // Also serves as repeated start, since the clock is low between bytes
  task start_cond;
    sda_m = 1'b1;
    #20 scl = 1'b1;
    #20 sda_m = 1'b0;
    #20 scl = 1'b0;
    #20;
  endtask

  task stop_cond;
    sda_m = 1'b0;
    #20 scl = 1'b1;
    #20 sda_m = 1'b1;
    #40;
  endtask

  // Data changes only while the clock is low, sampled mid high phase
  task bit_io(input logic b, output logic r);
    sda_m = b;
    #20 scl = 1'b1;
    #20 r = sda;
    #20 scl = 1'b0;
    #20;
  endtask

  task wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask

  // Ack the byte when ack is set, otherwise send a not-acknowledge; the caller marks the last byte
  task rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(!ack, r);
  endtask
endmodule

// ===== dv/codec_i2c_register_access_tb.sv
// Self-checking testbench for the codec two-wire register access port
`timescale 1ns/10ps

module codec_i2c_register_access_tb;
  import codec_i2c_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl;
  logic sda_m;
  wire logic sda;
  logic sda_out, sda_oe_n, wr_strobe, busy;
  logic [7:0] wr_addr, wr_data;
  int n_fail = 0;
  int checked = 0;
  int n_str = 0;

  always #2.5 sys_clk = ~sys_clk;

  // Pulled-up wire: low if either party pulls it
  assign sda = sda_m & (sda_oe_n | sda_out);

  i2c_master_model m (.scl(scl), .sda_m(sda_m), .sda(sda));

  codec_i2c_register_access dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data), .busy(busy)
  );

  // Count stores so a lost or doubled strobe shows up
  always @(posedge sys_clk) begin
    if (wr_strobe === 1'b1) begin
      n_str++;
    end
  end

  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task wb(input logic [7:0] b, input logic exp);
    logic a;
    m.wbyte(b, a);
    check("ack", {7'h00, a}, {7'h00, exp});
  endtask

  task rd(input logic ack, input logic [7:0] exp);
    logic [7:0] d;
    m.rbyte(ack, d);
    check("read", d, exp);
  endtask

  task t_write;
    m.start_cond();
    wb(8'h40, 1'b1);
    wb(8'h00, 1'b1);
    wb(8'h11, 1'b1);
    wb(8'h22, 1'b1);
    m.stop_cond();
    // Last implemented index; the master never writes beyond it
    m.start_cond();
    wb(8'h40, 1'b1);
    wb(8'h1C, 1'b1);
    wb(8'h5A, 1'b1);
    m.stop_cond();
    check("strobes", 8'(n_str), 8'h03);
    check("wr_addr", wr_addr, 8'h1C);
    check("wr_data", wr_data, 8'h5A);
    check("busy", {7'h00, busy}, 8'h00);
    $display("test write done");
  endtask

  task t_indexed;
    m.start_cond();
    wb(8'h40, 1'b1);
    wb(8'h1B, 1'b1);
    m.start_cond();
    wb(8'h41, 1'b1);
    rd(1'b1, 8'h00);
    rd(1'b1, 8'h5A);
    // Index 0x1D is reserved and reads back as zero
    rd(1'b0, 8'h00);
    check("busy", {7'h00, busy}, 8'h01);
    m.stop_cond();
    check("release", {7'h00, sda_oe_n}, 8'h01);
    $display("test indexed read done");
  endtask

  task t_from_zero;
    m.start_cond();
    wb(8'h41, 1'b1);
    rd(1'b1, 8'h11);
    rd(1'b0, 8'h22);
    m.stop_cond();
    // A preset closed by a stop is dropped
    m.start_cond();
    wb(8'h40, 1'b1);
    wb(8'h1C, 1'b1);
    m.stop_cond();
    m.start_cond();
    wb(8'h41, 1'b1);
    rd(1'b0, 8'h11);
    m.stop_cond();
    $display("test read from zero done");
  endtask

  task t_other_addr;
    m.start_cond();
    wb(8'h42, 1'b0);
    wb(8'h00, 1'b0);
    m.stop_cond();
    check("strobes", 8'(n_str), 8'h03);
    $display("test foreign address done");
  endtask

  task final_report;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // All frames together take about 17 us; the limit leaves wide margin
  initial begin
    #400000;
    n_fail++;
    final_report();
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (10) @(posedge sys_clk);
    // Model delays are whole clock multiples, so every pin change lands 1 ns after an edge
    #1;
    t_write();
    t_indexed();
    t_from_zero();
    t_other_addr();
    final_report();
  end
endmodule
